// ### src/kfr_rx.sv
// Operation
// - Normal packet is 16 bytes: preamble, sync, identifier, status, counter, checksum.
// - Five 0xAA preamble bytes then sync 0x2D, 0xD4 mark packet start.
// - Four-byte identifier after sync tells keyfobs apart.
// - Low five status bits give the pressed button.
// - CRC-16 poly x16+x15+x2+1, init 0xFFFF; mismatching packets rejected.
// - Bit recovery is dimensioned for 9.6 kBd.
// - Legacy word: 22 address bits then 2 data bits.
// - Legacy address is the identifier's low 22 bits.
// - Legacy bit spans three 3 kHz periods, decoded from its level pattern.
// - While unpaired, all four LEDs blink.
// - First valid packet while unpaired stores its identifier, enters receive mode.
// - Receive mode indicator stays lit in receive mode.
// - Receive mode accepts matching identifiers only and flashes the button's LEDs.
// - Pairing clear button erases the identifier and returns to waiting.
// - Selector pins sampled once after startup; later changes ignored.
// - Reception starts on its own once configuration is loaded.
// - Demodulated stream is presented on one data output pin.
module kfr_rx #(
    parameter int BIT_CYC_P = kfr_pkg::BIT_CYC,
    parameter int LEG_PER_P = kfr_pkg::LEG_PER_CYC,
    parameter int BLINK_P = kfr_pkg::BLINK_CYC,
    parameter int FLASH_P = kfr_pkg::FLASH_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic rx_data_in,
    input wire logic pairing_clear_button_in,
    input wire logic config_selector_pin_0_in,
    input wire logic config_selector_pin_1_in,
    input wire logic config_selector_pin_2_in,
    input wire logic config_selector_pin_3_in,
    output logic demod_data_out,
    output logic rx_active_out,
    output logic [kfr_pkg::LED_W-1:0] led_out,
    output logic paired_out
);
    import kfr_pkg::*;

    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC_P - 1);
    localparam logic [CNT_W-1:0] BIT_MID = CNT_W'(BIT_CYC_P / 2);
    localparam logic [CNT_W-1:0] LEG_MID = CNT_W'(LEG_PER_P + LEG_PER_P / 2);
    localparam logic [CNT_W-1:0] LEG_LAST = CNT_W'(LEG_PER_P * LEG_PER_PER_BIT - 1);
    localparam logic [CNT_W-1:0] PILOT = CNT_W'(LEG_PER_P * LEG_PILOT_PER);
    localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_P - 1);
    localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_P - 1);

    // One serial CRC step, MSB first
    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
        crc_step = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ b) ? CRC_POLY : 16'h0000);
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    logic [1:0] rx_sync_reg;
    logic [1:0] btn_sync_reg;
    logic [SEL_W-1:0] sel_meta_reg;
    logic [SEL_W-1:0] sel_sync_reg;
    logic rx_s;
    logic btn_s;

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_sync_reg <= 2'h0;
            btn_sync_reg <= 2'h0;
            sel_meta_reg <= 4'h0;
            sel_sync_reg <= 4'h0;
        end
        else
        begin
            rx_sync_reg <= {rx_sync_reg[0], rx_data_in};
            btn_sync_reg <= {btn_sync_reg[0], pairing_clear_button_in};
            sel_meta_reg <= {config_selector_pin_3_in, config_selector_pin_2_in,
                             config_selector_pin_1_in, config_selector_pin_0_in};
            sel_sync_reg <= sel_meta_reg;
        end
    end

    assign rx_s = rx_sync_reg[1];
    assign btn_s = btn_sync_reg[1];
    ////////////////////////////////////////////////////////////////////////////////
    // Startup configuration capture; strap taken after release, never in reset
    logic [CFG_W-1:0] cfg_wait_reg;
    logic [SEL_W-1:0] cfg_reg;
    logic rx_on_reg;
    logic legacy;

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cfg_wait_reg <= 3'h0;
            cfg_reg <= 4'h0;
            rx_on_reg <= 1'b0;
        end
        else if (!rx_on_reg)
        begin
            cfg_wait_reg <= cfg_wait_reg + 3'h1;
            if (cfg_wait_reg == CFG_W'(CFG_WAIT))
            begin
                cfg_reg <= sel_sync_reg;
                rx_on_reg <= 1'b1;
            end
        end
    end

    assign legacy = (cfg_reg == LEG_SEL);
    assign rx_active_out = rx_on_reg;
    // Retimed demodulated stream, held low until reception starts
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            demod_data_out <= 1'b0;
        else
            demod_data_out <= rx_on_reg & rx_s;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bit timer: normal mode resyncs on every edge, legacy on falling edges
    logic prev_rx_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [CNT_W-1:0] low_cnt_reg;
    logic rx_edge;
    logic rx_fall;
    logic bit_smp;

    assign rx_edge = rx_s ^ prev_rx_reg;
    assign rx_fall = (prev_rx_reg & ~rx_s) | (low_cnt_reg == PILOT); // Pilot holds timer
    assign bit_smp = rx_on_reg && (bit_cnt_reg == (legacy ? LEG_MID : BIT_MID));
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prev_rx_reg <= 1'b0;
            bit_cnt_reg <= '0;
            low_cnt_reg <= '0;
        end
        else
        begin
            prev_rx_reg <= rx_s;
            if ((legacy ? rx_fall : rx_edge) || bit_cnt_reg == (legacy ? LEG_LAST : BIT_LAST))
                bit_cnt_reg <= '0;
            else
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
            // Saturating low-run length for the legacy pilot
            if (rx_s)
                low_cnt_reg <= '0;
            else if (low_cnt_reg != PILOT)
                low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Framer for both formats
    kfr_frame_e fr_reg;
    logic [23:0] hunt_reg;
    logic [BODY_BITS-1:0] body_reg;
    logic [BIDX_W-1:0] bidx_reg;
    logic [CRC_W-1:0] crc_reg;
    logic pkt_ok_reg;
    logic [ID_W-1:0] pkt_id_reg;
    logic [BTN_W-1:0] pkt_btn_reg;
    logic [BODY_BITS-1:0] body_next;

    assign body_next = {body_reg[BODY_BITS-2:0], rx_s};
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            fr_reg <= FR_HUNT;
            hunt_reg <= '0;
            body_reg <= '0;
            bidx_reg <= '0;
            crc_reg <= CRC_INIT;
            pkt_ok_reg <= 1'b0;
            pkt_id_reg <= '0;
            pkt_btn_reg <= '0;
        end
        else
        begin
            pkt_ok_reg <= 1'b0;
            case (fr_reg)
                FR_HUNT:
                begin
                    if (legacy && low_cnt_reg == PILOT)
                    begin
                        fr_reg <= FR_PILOT;
                        bidx_reg <= '0;
                    end
                    else if (!legacy && bit_smp)
                    begin
                        hunt_reg <= {hunt_reg[22:0], rx_s};
                        if ({hunt_reg[22:0], rx_s} == HUNT_PAT)
                        begin
                            fr_reg <= FR_BODY;
                            bidx_reg <= '0;
                            crc_reg <= CRC_INIT;
                        end
                    end
                end
                FR_BODY:
                begin
                    if (bit_smp)
                    begin
                        body_reg <= body_next;
                        bidx_reg <= bidx_reg + 1'b1;
                        if (bidx_reg < BIDX_W'(COV_BITS))
                            crc_reg <= crc_step(crc_reg, rx_s);
                        if (bidx_reg == BIDX_W'(BODY_BITS - 1))
                        begin
                            // Packet counter bits are carried but unused
                            pkt_ok_reg <= (body_next[CRC_W-1:0] == crc_reg);
                            pkt_id_reg <= body_next[ID_LSB +: ID_W];
                            pkt_btn_reg <= body_next[STAT_LSB +: BTN_W];
                            hunt_reg <= '0;
                            fr_reg <= FR_HUNT;
                        end
                    end
                end
                FR_PILOT:
                begin
                    if (bit_smp)
                    begin
                        body_reg <= body_next;
                        bidx_reg <= bidx_reg + 1'b1;
                        if (bidx_reg == BIDX_W'(LEG_BITS - 1))
                        begin
                            pkt_ok_reg <= 1'b1;
                            pkt_id_reg <= ID_W'(body_next[LEG_BITS-1:LEG_DATA_W]);
                            pkt_btn_reg <= BTN_W'(body_next[LEG_DATA_W-1:0]);
                            fr_reg <= FR_HUNT;
                        end
                    end
                    // A long low mid-word means a broken word; restart
                    if (low_cnt_reg == PILOT && bidx_reg != '0)
                        bidx_reg <= '0;
                end
                default:
                    fr_reg <= FR_HUNT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pairing state; volatile, so reset always lands in waiting
    kfr_pair_e pair_reg;
    logic [ID_W-1:0] pair_id_reg;
    logic btn_prev_reg;
    logic clr_press;
    logic id_match;
    assign clr_press = btn_s & ~btn_prev_reg;
    assign id_match = legacy ? (pkt_id_reg[LEG_ADDR_W-1:0] == pair_id_reg[LEG_ADDR_W-1:0])
                             : (pkt_id_reg == pair_id_reg);

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pair_reg <= PR_WAIT;
            pair_id_reg <= '0;
            btn_prev_reg <= 1'b0;
        end
        else
        begin
            btn_prev_reg <= btn_s;
            if (clr_press)
            begin
                pair_reg <= PR_WAIT;
                pair_id_reg <= '0;
            end
            else if (pair_reg == PR_WAIT && pkt_ok_reg)
            begin
                pair_id_reg <= pkt_id_reg;
                pair_reg <= PR_RECV;
            end
        end
    end

    assign paired_out = (pair_reg == PR_RECV);
    ////////////////////////////////////////////////////////////////////////////////
    // LED timing: blink while waiting, flash subset per accepted packet
    logic [CNT_W-1:0] blink_cnt_reg;
    logic blink_reg;
    logic [CNT_W-1:0] flash_cnt_reg;
    logic [LED_W-2:0] flash_set_reg;
    logic [LED_W-2:0] btn_leds;
    // Button code to indicator subset; an empty subset lights all three
    assign btn_leds = (pkt_btn_reg[LED_W-2:0] == '0) ? '1 : pkt_btn_reg[LED_W-2:0];

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
            flash_cnt_reg <= '0;
            flash_set_reg <= '0;
        end
        else
        begin
            if (blink_cnt_reg == BLINK_LAST)
            begin
                blink_cnt_reg <= '0;
                blink_reg <= ~blink_reg;
            end
            else
                blink_cnt_reg <= blink_cnt_reg + 1'b1;
            // Repeats of the same press just restart the flash
            if (pair_reg == PR_RECV && pkt_ok_reg && id_match && !clr_press)
            begin
                flash_set_reg <= btn_leds;
                flash_cnt_reg <= FLASH_LAST;
            end
            else if (flash_cnt_reg != '0)
                flash_cnt_reg <= flash_cnt_reg - 1'b1;
            else
                flash_set_reg <= '0;
        end
    end

    // Output mux from registered state only
    always_comb
    begin
        if (pair_reg == PR_WAIT)
            led_out = {LED_W{blink_reg}};
        else
        begin
            led_out = {flash_set_reg, 1'b0};
            led_out[LED_RX_IDX] = 1'b1;
        end
    end
endmodule : kfr_rx

// ### src/kfr_pkg.sv
package kfr_pkg;
    // Clock and link timing
    localparam int CLK_HZ = 250_000_000;
    localparam int SYM_RATE_BD = 9600;
    localparam int BIT_CYC = CLK_HZ / SYM_RATE_BD;
    localparam int LEG_CLK_HZ = 3000;
    localparam int LEG_PER_CYC = CLK_HZ / LEG_CLK_HZ;
    localparam int LEG_PER_PER_BIT = 3;
    localparam int LEG_PILOT_PER = 10;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
    localparam int FLASH_MS = 100;
    localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    localparam int CNT_W = 27;
    localparam int CFG_WAIT = 4;
    localparam int CFG_W = 3;

    // Normal packet layout
    localparam int PRE_BYTES = 5;
    localparam int SYNC_BYTES = 2;
    localparam int ID_BYTES = 4;
    localparam int STAT_BYTES = 1;
    localparam int PCNT_BYTES = 2;
    localparam int CRC_BYTES = 2;
    localparam int PKT_BYTES = PRE_BYTES + SYNC_BYTES + ID_BYTES + STAT_BYTES
                             + PCNT_BYTES + CRC_BYTES;
    localparam int COV_BITS = (ID_BYTES + STAT_BYTES + PCNT_BYTES) * 8;
    localparam int BODY_BITS = COV_BITS + CRC_BYTES * 8;
    localparam int BIDX_W = 7;
    localparam logic [7:0] PRE_BYTE = 8'hAA;
    localparam logic [7:0] SYNC_HI = 8'h2D;
    localparam logic [7:0] SYNC_LO = 8'hD4;
    localparam logic [23:0] HUNT_PAT = {PRE_BYTE, SYNC_HI, SYNC_LO};
    localparam int ID_W = 32;
    localparam int BTN_W = 5;
    localparam int CRC_W = 16;
    localparam int STAT_LSB = CRC_W + PCNT_BYTES * 8;
    localparam int ID_LSB = STAT_LSB + STAT_BYTES * 8;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    // Legacy encoder word
    localparam int LEG_ADDR_W = 22;
    localparam int LEG_DATA_W = 2;
    localparam int LEG_BITS = LEG_ADDR_W + LEG_DATA_W;

    // Selector and indicators
    localparam int SEL_W = 4;
    localparam logic [3:0] LEG_SEL = 4'h0;
    localparam int LED_W = 4;
    localparam int LED_RX_IDX = 0;

    typedef enum logic [0:0] {PR_WAIT = 1'b0, PR_RECV = 1'b1} kfr_pair_e;
    typedef enum logic [1:0] {FR_HUNT = 2'b00, FR_BODY = 2'b01, FR_PILOT = 2'b10} kfr_frame_e;
endpackage : kfr_pkg

// ### test/kfr_rx_monitor.sv
module kfr_rx_monitor #(
    parameter int BLINK_P = 16,
    parameter int FLASH_P = 16
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic rx_data_in,
    input wire logic pairing_clear_button_in,
    input wire logic demod_data_out,
    input wire logic rx_active_out,
    input wire logic [kfr_pkg::LED_W-1:0] led_out,
    input wire logic paired_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import kfr_pkg::*;
    logic [31:0] still_cnt_reg;
    logic [31:0] flash_cnt_reg;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Steady blink phase length while unpaired
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            still_cnt_reg <= '0;
        else if (paired_out || led_out != $past(led_out))
            still_cnt_reg <= '0;
        else
            still_cnt_reg <= still_cnt_reg + 32'h1;
    end
    // Flash length in receive mode
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            flash_cnt_reg <= '0;
        else if (!paired_out || led_out[3:1] == 3'h0)
            flash_cnt_reg <= '0;
        else
            flash_cnt_reg <= flash_cnt_reg + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Press held long enough to pass the synchroniser
    sequence s_press;
        $rose(pairing_clear_button_in) ##1 pairing_clear_button_in [*3];
    endsequence
    a_blink_all: assert property (!paired_out |-> led_out inside {4'h0, 4'hF})
        else $error("unpaired leds not all equal");
    a_blink_rate: assert property (still_cnt_reg <= BLINK_P + 1)
        else $error("blink stopped while unpaired");
    a_pair_shows: assert property ($rose(paired_out) |-> led_out == 4'h1 && rx_active_out)
        else $error("pairing shown wrongly");
    a_rx_lit: assert property (paired_out |-> led_out[LED_RX_IDX])
        else $error("receive indicator dark");
    a_flash_len: assert property (flash_cnt_reg <= FLASH_P + 1)
        else $error("flash too long");
    a_clear_acts: assert property (s_press |-> ##[0:4] !paired_out)
        else $error("clear press ignored");
    a_clear_cause: assert property ($fell(paired_out) |-> $past(pairing_clear_button_in, 3))
        else $error("pairing lost without press");
    a_active_up: assert property ($rose(rst_b_in) |-> ##[1:10] rx_active_out)
        else $error("reception did not start");
    a_active_hold: assert property (rx_active_out |=> rx_active_out)
        else $error("reception stopped");
    a_demod_off: assert property (!rx_active_out |-> !demod_data_out)
        else $error("stream before start");
    a_demod_follow: assert property (rx_active_out && $past(rx_active_out, 3)
        |-> demod_data_out == $past(rx_data_in, 3))
        else $error("stream not retimed");
endmodule : kfr_rx_monitor

// ### test/kfr_fob_model.sv
module kfr_fob_model #(
    parameter int BIT_CYC_P = 20,
    parameter int LEG_PER_P = 20
) (
    input wire logic core_clk_in,
    output logic rx_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Radio output rests low between frames
    initial rx_data_out = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // Bitwise checksum, MSB first, no reflection
    function automatic logic [15:0] crc_calc(input logic [55:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 55; i >= 0; i--)
        begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction : crc_calc
    // Hold one level for a number of cycles
    task automatic put(input logic v, input int n);
        rx_data_out = v;
        repeat (n) @(negedge core_clk_in);
    endtask : put
    // Normal packet, NRZ at the symbol rate; bad_crc flips the last bit
    task automatic send_pkt(input logic [31:0] id, input logic [7:0] st,
                            input logic [15:0] cnt, input logic [7:0] sy_lo, input logic bad_crc);
        logic [127:0] f;
        f = {{5{8'hAA}}, 8'h2D, sy_lo, id, st, cnt,
             crc_calc({id, st, cnt}) ^ {15'h0000, bad_crc}};
        for (int i = 127; i >= 0; i--)
            put(f[i], BIT_CYC_P);
        put(1'b0, 40);
    endtask : send_pkt
    // One press repeats the same packet four times
    task automatic send_press(input logic [31:0] id, input logic [7:0] st, input logic [15:0] cnt);
        repeat (4) send_pkt(id, st, cnt, 8'hD4, 1'b0);
    endtask : send_press
    // Legacy word: pilot, then low/value/high thirds per bit
    task automatic send_leg(input logic [21:0] addr, input logic [1:0] dat);
        logic [23:0] w;
        w = {addr, dat};
        put(1'b0, 12 * LEG_PER_P);
        put(1'b1, LEG_PER_P);
        for (int i = 23; i >= 0; i--)
        begin
            put(1'b0, LEG_PER_P);
            put(w[i], LEG_PER_P);
            put(1'b1, LEG_PER_P);
        end
        put(1'b1, 2 * LEG_PER_P);
        put(1'b0, 60);
    endtask : send_leg
endmodule : kfr_fob_model

// ### test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import kfr_pkg::*;
    localparam int BIT_P = 20;
    localparam int LEG_P = 20;
    localparam int BLK_P = 16;
    localparam int FLS_P = 16;
    logic core_clk_in, rst_b_in, btn, rx_data, act, dmod, paired;
    logic [3:0] sel, led, flash_led;
    logic [31:0] rnd, id_a;
    int failures, checked;
    kfr_rx #(.BIT_CYC_P(BIT_P), .LEG_PER_P(LEG_P), .BLINK_P(BLK_P), .FLASH_P(FLS_P)) i_dut (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .rx_data_in(rx_data),
        .pairing_clear_button_in(btn), .config_selector_pin_0_in(sel[0]),
        .config_selector_pin_1_in(sel[1]), .config_selector_pin_2_in(sel[2]),
        .config_selector_pin_3_in(sel[3]), .demod_data_out(dmod), .rx_active_out(act),
        .led_out(led), .paired_out(paired));
    kfr_fob_model #(.BIT_CYC_P(BIT_P), .LEG_PER_P(LEG_P)) i_fob (
        .core_clk_in(core_clk_in), .rx_data_out(rx_data));
    ////////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    // Latest flash pattern seen in receive mode
    always @(negedge core_clk_in)
        if (paired === 1'b1 && led !== 4'h1)
            flash_led = led;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Zero code lights all three button leds
    function automatic logic [3:0] exp_led(input logic [2:0] b);
        return {(b == 3'h0) ? 3'h7 : b, 1'b1};
    endfunction : exp_led
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit
    task automatic chk_led(input logic [3:0] got, input logic [3:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_led
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // Straps are set before reset and held through sampling
    task automatic do_reset(input logic [3:0] s);
        @(negedge core_clk_in);
        sel = s;
        rst_b_in = 1'b0;
        repeat (8) @(negedge core_clk_in);
        rst_b_in = 1'b1;
        for (int i = 0; i < 12 && act !== 1'b1; i++)
            @(negedge core_clk_in);
    endtask : do_reset
    task automatic pkt(input logic [31:0] id, input logic [7:0] st);
        rnd = xs(rnd);
        flash_led = 4'h0;
        i_fob.send_pkt(id, st, rnd[15:0], 8'hD4, 1'b0);
    endtask : pkt
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: normal format first, then legacy format
    initial
    begin
        int tog;
        {btn, sel, rst_b_in, failures, checked, flash_led} = '0;
        rnd = xs(32'hA10B8407);
        id_a = rnd;
        do_reset(rnd[7:4] | 4'h1);
        chk_bit(act, 1'b1, "start");
        tog = 0;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge core_clk_in);
            tog += (led inside {4'h0, 4'hF}) ? int'(led == 4'hF) : 100; // Mixed leds spoil count
        end
        chk_bit(tog > 0 && tog < 40, 1'b1, "blink");
        i_fob.send_pkt(id_a, 8'h01, 16'h0001, 8'hD4, 1'b1);
        chk_bit(paired, 1'b0, "bad crc");
        i_fob.send_pkt(id_a, 8'h01, 16'h0002, 8'hD5, 1'b0);
        chk_bit(paired, 1'b0, "bad sync");
        pkt(id_a, 8'h01);
        chk_bit(paired, 1'b1, "pair");
        chk_led(led, 4'h1, "lit");
        for (int b = 0; b < 8; b++)
        begin
            pkt(id_a, {rnd[23:19], 3'(b)});
            chk_led(flash_led, exp_led(3'(b)), "button");
        end
        flash_led = 4'h0;
        i_fob.send_press(id_a, 8'hE2, 16'h0100);
        chk_led(flash_led, exp_led(3'h2), "repeats");
        pkt(~id_a, 8'h03);
        chk_led(flash_led, 4'h0, "other fob");
        sel = 4'h0;
        pkt(id_a, 8'h03);
        chk_led(flash_led, exp_led(3'h3), "late straps");
        btn = 1'b1;
        repeat (10) @(negedge core_clk_in);
        btn = 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk_bit(paired, 1'b0, "clear");
        pkt(~id_a, 8'h05);
        chk_bit(paired, 1'b1, "repair");
        do_reset(4'h0);
        chk_bit(paired, 1'b0, "reset");
        i_fob.send_leg(id_a[21:0], 2'b01);
        chk_bit(paired, 1'b1, "leg pair");
        flash_led = 4'h0;
        i_fob.send_leg(~id_a[21:0], 2'b10);
        chk_led(flash_led, 4'h0, "leg other");
        i_fob.send_leg(id_a[21:0], 2'b10);
        chk_led(flash_led, exp_led(3'h2), "leg data");
        summarize();
    end
    // About 50k cycles of traffic expected; allow about twice that
    initial
    begin
        repeat (100000) @(posedge core_clk_in);
        failures++;
        summarize();
    end
endmodule : tb_top

bind kfr_rx kfr_rx_monitor #(.BLINK_P(BLINK_P), .FLASH_P(FLASH_P)) i_mon (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .rx_data_in(rx_data_in),
    .pairing_clear_button_in(pairing_clear_button_in), .demod_data_out(demod_data_out),
    .rx_active_out(rx_active_out), .led_out(led_out), .paired_out(paired_out));
